// File: wdt_pkg.sv
/*
 windowed watchdog constants, register layout and carrier types.
 assumes one core clock domain; the slow tick arrives as an asynchronous pin.
*/
package wdt_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] CTRL_INDEX = 6'h00;
   localparam logic [5:0] STATE_INDEX = 6'h01;
   localparam logic [5:0] GUARD_INDEX = 6'h02;
   localparam int LOCK_BIT = 7;
   localparam int PENDING_BIT = 0;
   localparam int GUARD_OPEN_BIT = 0;
   localparam logic [3:0] CODE_OFF = 4'h0;
   localparam logic [3:0] PERIOD_CODE_MAX = 4'hA;
   localparam logic [3:0] WINDOW_CODE_MAX = 4'hB;
   localparam logic [13:0] BASE_TICKS = 14'h0008;
   localparam logic [2:0] GUARD_INSTR = 3'h4;
   localparam logic [1:0] CTRL_SYNC_TICKS = 2'h2;
   localparam logic [1:0] RESTART_SYNC_TICKS = 2'h3;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;
   localparam int CORE_CLK_PERIOD_NS = 5;
   localparam int SLOW_TICK_HZ_X1000 = 1024000;
   typedef struct packed {
      logic [3:0] window;
      logic [3:0] period;
   } ctrl_type;
   typedef enum logic {PH_CLOSED, PH_OPEN} phase_type;
endpackage : wdt_pkg

// File: windowed_watchdog_timer.sv
/*
 windowed watchdog with AHB-Lite register slave, zero wait states.
 assumes slow tick pin is asynchronous, the cpu strobes are on core_clk,
 and system reset logic acknowledges the request with a pulse.
*/
`timescale 1ns/1ps
module windowed_watchdog_timer #(
   parameter logic [7:0] UNLOCK_KEY = 8'hA5 // arbitrary unlock value
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // cpu side
   input wire logic restartInstr,
   input wire logic cpuInstr,
   input wire logic debugHalt,
   // slow tick pin and fuse
   input wire logic slowTickClock,
   input wire wdt_pkg::ctrl_type fuseWatchConfig,
   // system reset handshake
   output logic sysResetReq,
   input wire logic sysResetAck
);
   import wdt_pkg::*;

   // decoding used for both time-out and closed span
   function automatic logic [13:0] tick_len(input logic [3:0] code, input logic [3:0] max);
      logic [3:0] c;
      c = (code > max) ? max : code;
      return 14'(BASE_TICKS << (c - 4'h1));
   endfunction : tick_len

   // slow tick synchroniser
   logic tickS1, tickS2, tickS3, tickLevel;
   always_ff @(posedge core_clk) begin
      tickS1 <= slowTickClock;
      tickS2 <= tickS1;
      tickS3 <= tickS2;
   end
   wire tickAgree = (tickS2 == tickS3);
   wire tick = tickAgree & tickS3 & ~tickLevel;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tickLevel <= 1'b0;
      end else if (tickAgree) begin
         tickLevel <= tickS3;
      end
   end

   // bus address phase
   logic dataWr, dataRd;
   logic [5:0] dataIdx;
   wire addrPhase = hsel & hready & htrans[1];
   wire [5:0] addrIdx = haddr[7:2];
   wire addrMapped = (haddr[31:8] == 24'h000000) && (addrIdx <= GUARD_INDEX);
   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dataWr <= 1'b0;
         dataRd <= 1'b0;
         dataIdx <= 6'h00;
      end else begin
         dataWr <= addrPhase & hwrite & addrMapped;
         dataRd <= addrPhase & ~hwrite;
         dataIdx <= addrIdx;
      end
   end

   // registers
   ctrl_type ctrl, actCtrl;
   logic lock;
   logic [2:0] guardLeft;
   logic [1:0] ctrlSync, restartSync;
   wire guardOpen = (guardLeft != 3'h0);
   wire wrCtrlReq = dataWr & (dataIdx == CTRL_INDEX);
   wire wrState = dataWr & (dataIdx == STATE_INDEX) & guardOpen;
   wire wrGuard = dataWr & (dataIdx == GUARD_INDEX);
   wire wrCtrl = wrCtrlReq & guardOpen & ~lock;
   wire busy = (ctrlSync != 2'h0);
   wire ctrlApply = tick & (ctrlSync == 2'h1);
   wire restartApply = tick & (restartSync == 2'h1);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         guardLeft <= 3'h0;
      end else if (wrGuard & (hwdata[7:0] == UNLOCK_KEY)) begin
         guardLeft <= GUARD_INSTR;
      end else if (wrCtrl | wrState) begin
         guardLeft <= 3'h0;
      end else if (cpuInstr & guardOpen) begin
         guardLeft <= guardLeft - 3'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl <= fuseWatchConfig;
      end else if (wrCtrl) begin
         ctrl <= ctrl_type'(hwdata[7:0]);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         lock <= (fuseWatchConfig.period != CODE_OFF);
      end else if (wrState & hwdata[LOCK_BIT]) begin
         lock <= 1'b1;
      end else if (wrState & debugHalt) begin
         lock <= 1'b0;
      end
   end

   // pending until crossed; software keeps ctrl still meanwhile
   // relies on no write while pending
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrlSync <= 2'h0;
         actCtrl <= fuseWatchConfig;
      end else if (wrCtrl) begin
         ctrlSync <= CTRL_SYNC_TICKS;
      end else if (tick & busy) begin
         ctrlSync <= ctrlSync - 2'h1;
         if (ctrlSync == 2'h1) begin
            actCtrl <= ctrl;
         end
      end
   end

   // restart crosses in two to three ticks
   always_ff @(posedge core_clk) begin
      if (rst) begin
         restartSync <= 2'h0;
      end else if (restartInstr & (restartSync == 2'h0)) begin
         restartSync <= RESTART_SYNC_TICKS;
      end else if (tick & (restartSync != 2'h0)) begin
         restartSync <= restartSync - 2'h1;
      end
   end

   // read data registered in address phase
   wire [7:0] stateView = {lock, 6'h00, busy};
   wire [7:0] guardView = {7'h00, guardOpen};
   wire [7:0] readSel = (addrIdx == CTRL_INDEX) ? ctrl :
                        (addrIdx == STATE_INDEX) ? stateView :
                        (addrIdx == GUARD_INDEX) ? guardView : 8'h00;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         hrdata <= 32'h00000000;
      end else if (addrPhase & ~hwrite) begin
         hrdata <= {24'h000000, addrMapped ? readSel : 8'h00};
      end
   end

   // watchdog core
   logic [13:0] count;
   phase_type phase;
   logic armed;
   wire enabled = (actCtrl.period != CODE_OFF);
   wire windowOn = (actCtrl.window != CODE_OFF);
   wire useWindow = windowOn & armed;
   wire [13:0] openLen = tick_len(actCtrl.period, PERIOD_CODE_MAX);
   wire [13:0] closedLen = tick_len(actCtrl.window, WINDOW_CODE_MAX);
   wire inClosed = useWindow & (phase == PH_CLOSED);
   wire [13:0] limit = inClosed ? closedLen : openLen;
   // counts on each slow tick while enabled and not in debug halt; no sleep gating
   wire counting = tick & enabled & ~debugHalt;
   wire atEnd = (count >= limit - 14'h0001);
   wire expire = counting & atEnd & ~inClosed & ~restartApply;
   // closed period hands over to open
   wire closeEnd = counting & atEnd & inClosed & ~restartApply;
   wire earlyRestart = restartApply & enabled & inClosed & ~debugHalt;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         count <= 14'h0000;
         phase <= PH_CLOSED;
         armed <= 1'b0;
      end else if (debugHalt) begin
         // first period after resume is normal
         count <= 14'h0000;
         armed <= 1'b0;
      end else if (!enabled) begin
         count <= 14'h0000;
         armed <= 1'b0;
      end else if (restartApply) begin
         count <= 14'h0000;
         phase <= PH_CLOSED;
         armed <= windowOn;
      end else if (closeEnd) begin
         count <= 14'h0000;
         phase <= PH_OPEN;
      end else if (!windowOn) begin
         armed <= 1'b0;
         if (counting) begin
            count <= count + 14'h0001;
         end
      end else if (counting) begin
         count <= count + 14'h0001;
      end
   end

   // request held until acknowledge; new event wins
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sysResetReq <= 1'b0;
      end else if (expire | earlyRestart) begin
         sysResetReq <= 1'b1;
      end else if (sysResetAck) begin
         sysResetReq <= 1'b0;
      end
   end

   // checks
   a_disabled_idle: assert property (@(posedge core_clk) disable iff (rst)
      !enabled |=> count == 14'h0000) else $error("count moved while disabled");
   a_normal_expire: assert property (@(posedge core_clk) disable iff (rst)
      (counting && !inClosed && count == limit - 14'h0001 && !restartApply) |=> sysResetReq)
      else $error("time-out gave no reset request");
   a_restart_clear: assert property (@(posedge core_clk) disable iff (rst)
      (restartApply && !earlyRestart) |=> count == 14'h0000) else $error("restart kept count");
   a_early_reset: assert property (@(posedge core_clk) disable iff (rst)
      earlyRestart |=> sysResetReq) else $error("closed restart not punished");
   a_open_follows: assert property (@(posedge core_clk) disable iff (rst)
      closeEnd && !debugHalt |=> phase == PH_OPEN && count == 14'h0000)
      else $error("open period did not start");
   a_freeze_ctrl: assert property (@(posedge core_clk) disable iff (rst)
      lock |=> $stable(ctrl)) else $error("frozen control changed");
   a_lock_sticky: assert property (@(posedge core_clk) disable iff (rst)
      lock && !debugHalt |=> lock) else $error("freeze cleared outside debug");
   a_unguarded_hold: assert property (@(posedge core_clk) disable iff (rst)
      wrCtrlReq && !guardOpen |=> $stable(ctrl)) else $error("unguarded write took effect");
   a_pending_rise: assert property (@(posedge core_clk) disable iff (rst)
      wrCtrl |=> busy ##0 ctrl == $past(ctrl_type'(hwdata[7:0])))
      else $error("pending flag not raised");
   a_restart_delay: assert property (@(posedge core_clk) disable iff (rst)
      restartInstr && restartSync == 2'h0 |=> restartSync == RESTART_SYNC_TICKS)
      else $error("restart delay not started");
   a_halt_clear: assert property (@(posedge core_clk) disable iff (rst)
      debugHalt |=> count == 14'h0000 && !armed) else $error("halt kept count");
   a_req_held: assert property (@(posedge core_clk) disable iff (rst)
      sysResetReq && !sysResetAck |=> sysResetReq) else $error("reset request dropped");
   a_count_step: assert property (@(posedge core_clk) disable iff (rst)
      counting && !restartApply && !closeEnd |=> count == $past(count) + 14'h0001)
      else $error("count did not advance on tick");

   a_count_still: assert property (@(posedge core_clk) disable iff (rst)
      !tick && !restartApply && enabled && !debugHalt |=> $stable(count))
      else $error("count moved without a tick");

   a_tick_single: assert property (@(posedge core_clk) disable iff (rst)
      tick |=> !tick)
      else $error("slow edge counted twice");

   a_window_arm: assert property (@(posedge core_clk) disable iff (rst)
      restartApply && enabled && !debugHalt && windowOn |=> armed)
      else $error("restart did not arm window");

   a_normal_unarmed: assert property (@(posedge core_clk) disable iff (rst)
      !windowOn |=> !armed)
      else $error("window armed in normal mode");

   a_period_min: assert property (@(posedge core_clk) disable iff (rst)
      actCtrl.period == 4'h1 |-> openLen == 14'h0008)
      else $error("shortest time-out wrong");

   a_period_max: assert property (@(posedge core_clk) disable iff (rst)
      actCtrl.period == 4'hA |-> openLen == 14'h1000)
      else $error("longest time-out wrong");

   a_window_min: assert property (@(posedge core_clk) disable iff (rst)
      actCtrl.window == 4'h1 |-> closedLen == 14'h0008)
      else $error("shortest closed span wrong");

   a_window_max: assert property (@(posedge core_clk) disable iff (rst)
      actCtrl.window == 4'hB |-> closedLen == 14'h2000)
      else $error("longest closed span wrong");

   a_window_clamp: assert property (@(posedge core_clk) disable iff (rst)
      actCtrl.window == 4'hC |-> closedLen == 14'h2000)
      else $error("reserved closed span not clamped");

   a_req_rise: assert property (@(posedge core_clk) disable iff (rst)
      $rose(sysResetReq) |-> $past(expire | earlyRestart))
      else $error("reset request without cause");

   a_req_fall: assert property (@(posedge core_clk) disable iff (rst)
      $fell(sysResetReq) |-> $past(sysResetAck))
      else $error("reset request dropped without ack");

   a_pending_fall: assert property (@(posedge core_clk) disable iff (rst)
      $fell(busy) |-> $past(tick))
      else $error("pending flag fell without transfer");

   a_active_update: assert property (@(posedge core_clk) disable iff (rst)
      $changed(actCtrl) |-> $past(ctrlApply))
      else $error("active control changed early");

   a_pending_hold: assert property (@(posedge core_clk) disable iff (rst)
      busy && !tick |=> busy)
      else $error("pending flag fell between ticks");

   a_guard_reload: assert property (@(posedge core_clk) disable iff (rst)
      wrGuard && hwdata[7:0] == UNLOCK_KEY |=> guardLeft == GUARD_INSTR)
      else $error("unlock key did not open guard");

   a_guard_close: assert property (@(posedge core_clk) disable iff (rst)
      wrCtrl || wrState |=> !guardOpen)
      else $error("guard stayed open after write");

   a_lock_guarded: assert property (@(posedge core_clk) disable iff (rst)
      $changed(lock) |-> $past(guardOpen))
      else $error("freeze bit changed without unlock");

   a_lock_debug: assert property (@(posedge core_clk) disable iff (rst)
      $fell(lock) |-> $past(debugHalt))
      else $error("freeze bit cleared outside debug");

   a_fuse_lock: assert property (@(posedge core_clk)
      $fell(rst) |-> lock == (ctrl.period != CODE_OFF))
      else $error("fuse did not set freeze bit");

   a_open_expire: assert property (@(posedge core_clk) disable iff (rst)
      counting && atEnd && useWindow && phase == PH_OPEN && !restartApply |=> sysResetReq)
      else $error("open period expiry gave no reset");

   c_window_arm: cover property (@(posedge core_clk) disable iff (rst) restartApply && windowOn);
   c_early: cover property (@(posedge core_clk) disable iff (rst) earlyRestart);
   c_close_end: cover property (@(posedge core_clk) disable iff (rst) closeEnd);
   c_expire: cover property (@(posedge core_clk) disable iff (rst) expire);
   c_ctrl_apply: cover property (@(posedge core_clk) disable iff (rst) ctrlApply);
endmodule : windowed_watchdog_timer

// File: cpu_model.sv
/*
 cpu model: ahb-lite master transfers, restart and instruction strobes.
 assumes hready is the single slave's hreadyout and ticks are paced by the caller.
*/
`timescale 1ns/1ps
module cpu_model (
   // clock
   input wire logic core_clk,
   // ahb-lite master
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // cpu strobes
   output logic restartInstr,
   output logic cpuInstr
);
   import wdt_pkg::*;
   initial begin
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      restartInstr = 1'b0;
      cpuInstr = 1'b0;
   end
   // callers count instructions and wait out the sync
   task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] d,
      output logic [7:0] r);
      @(posedge core_clk);
      haddr <= {24'h0, idx, 2'b00};
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      do @(posedge core_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge core_clk); while (hready !== 1'b1);
      r = hrdata[7:0];
   endtask : xfer
   // one-cycle pulse; which high means restart
   task automatic strobe(input logic which);
      @(posedge core_clk);
      if (which)
         restartInstr <= 1'b1;
      else
         cpuInstr <= 1'b1;
      @(posedge core_clk);
      restartInstr <= 1'b0;
      cpuInstr <= 1'b0;
   endtask : strobe
endmodule : cpu_model

// File: testbench.sv
/*
 testbench: scenario tasks against the watchdog through the cpu model.
 assumes slow ticks may be driven fast, four core cycles per level.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("[ERR] %0t mismatch", $time); end end
module testbench;
   import wdt_pkg::*;
   localparam logic [7:0] KEY = 8'hA5;
   logic core_clk;
   logic rst;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic restartInstr;
   logic cpuInstr;
   logic debugHalt;
   logic slowTickClock;
   ctrl_type fuseWatchConfig;
   logic sysResetReq;
   logic sysResetAck;
   logic [7:0] r;
   int bad_count;
   int total_checks;
   windowed_watchdog_timer #(.UNLOCK_KEY(KEY)) i_windowed_watchdog_timer (
      .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .restartInstr(restartInstr), .cpuInstr(cpuInstr),
      .debugHalt(debugHalt), .slowTickClock(slowTickClock), .fuseWatchConfig(fuseWatchConfig),
      .sysResetReq(sysResetReq), .sysResetAck(sysResetAck));
   cpu_model i_cpu_model (
      .core_clk(core_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .restartInstr(restartInstr), .cpuInstr(cpuInstr));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic stop_test();
      if (bad_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test
   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      logic [7:0] x;
      i_cpu_model.xfer(1'b1, i, d, x);
   endtask : wr
   task automatic rd(input logic [5:0] i);
      i_cpu_model.xfer(1'b0, i, 8'h00, r);
   endtask : rd
   task automatic unlock(input int n);
      wr(GUARD_INDEX, KEY);
      repeat (n) i_cpu_model.strobe(1'b0);
   endtask : unlock
   // slow levels kept long enough for the three-flop sync
   task automatic tick(input int n);
      repeat (n) begin
         slowTickClock <= 1'b1;
         repeat (4) @(posedge core_clk);
         slowTickClock <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
   endtask : tick
   task automatic ack();
      @(posedge core_clk);
      sysResetAck <= 1'b1;
      @(posedge core_clk);
      sysResetAck <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask : ack
   task automatic s_fuse_lock();
      rd(STATE_INDEX);
      `CHK(r[LOCK_BIT], 1'b1)
      rd(CTRL_INDEX);
      `CHK(r, 8'h01)
      `CHK(hresp, HRESP_OKAY)
      unlock(2);
      wr(CTRL_INDEX, 8'h00);
      rd(CTRL_INDEX);
      `CHK(r, 8'h01)
      unlock(2);
      wr(STATE_INDEX, 8'h00);
      rd(STATE_INDEX);
      `CHK(r[LOCK_BIT], 1'b1)
      debugHalt <= 1'b1;
      unlock(2);
      wr(STATE_INDEX, 8'h00);
      rd(STATE_INDEX);
      `CHK(r[LOCK_BIT], 1'b0)
      tick(20);
      `CHK(sysResetReq, 1'b0)
      debugHalt <= 1'b0;
   endtask : s_fuse_lock
   task automatic s_guard_sync();
      wr(CTRL_INDEX, 8'h00);
      rd(CTRL_INDEX);
      `CHK(r, 8'h01)
      unlock(5);
      wr(CTRL_INDEX, 8'h00);
      rd(CTRL_INDEX);
      `CHK(r, 8'h01)
      unlock(3);
      wr(CTRL_INDEX, 8'h00);
      rd(STATE_INDEX);
      `CHK(r[PENDING_BIT], 1'b1)
      rd(CTRL_INDEX);
      `CHK(r, 8'h00)
      tick(2);
      rd(STATE_INDEX);
      `CHK(r[PENDING_BIT], 1'b0)
      rd(6'h3F);
      `CHK(r, 8'h00)
      tick(20);
      `CHK(sysResetReq, 1'b0)
   endtask : s_guard_sync
   task automatic s_normal();
      unlock(1);
      wr(CTRL_INDEX, 8'h01);
      tick(2);
      i_cpu_model.strobe(1'b1);
      tick(9);
      `CHK(sysResetReq, 1'b0)
      tick(3);
      `CHK(sysResetReq, 1'b1)
      unlock(1);
      wr(CTRL_INDEX, 8'h00);
      tick(2);
      `CHK(sysResetReq, 1'b1)
      ack();
      `CHK(sysResetReq, 1'b0)
   endtask : s_normal
   task automatic s_window();
      unlock(1);
      wr(CTRL_INDEX, 8'h11);
      tick(2);
      i_cpu_model.strobe(1'b1);
      tick(3);
      `CHK(sysResetReq, 1'b0)
      tick(9);
      i_cpu_model.strobe(1'b1);
      tick(3);
      `CHK(sysResetReq, 1'b0)
      i_cpu_model.strobe(1'b1);
      tick(3);
      `CHK(sysResetReq, 1'b1)
      ack();
   endtask : s_window
   initial begin
      rst = 1'b1;
      debugHalt = 1'b0;
      slowTickClock = 1'b0;
      fuseWatchConfig = 8'h01;
      sysResetAck = 1'b0;
      bad_count = 0;
      total_checks = 0;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      s_fuse_lock();
      s_guard_sync();
      s_normal();
      s_window();
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      stop_test();
   end
endmodule : testbench
